// [audio_route_consts.svh]
// offsets, field positions, codes and reset values of the routing and trim registers
`ifndef AUDIO_ROUTE_CONSTS_SVH
`define AUDIO_ROUTE_CONSTS_SVH

// control port geometry and default audio sample width
`define REG_ADDR_W 16
`define REG_DATA_W 16
`define SAMPLE_W_DEF 24

// register offsets on the control port
`define OFS_SOURCE_SELECT_TWO 16'h0101
`define OFS_INPUT_GAIN 16'h0102

// source-select field positions (lsb of each 4-bit field)
`define SRC_FIELD_W 4
`define SEL_SERIAL_OUT_ZERO_LSB 12
`define SEL_SPDIF_OUT_LSB 8
`define SEL_AUX_OUT_ONE_LSB 4
`define SEL_WRITE_MASK 16'hfff0
`define SEL_RESET 16'h0000

// source codes
`define CODE_CONV_IN_ONE 4'h1
`define CODE_SER_IN_ZERO 4'h3
`define CODE_SER_IN_ONE 4'h4
`define CODE_SER_IN_TWO 4'h5
`define CODE_SER_IN_THREE 4'h6
`define CODE_RATE_CONV_ONE 4'h7
`define CODE_RATE_CONV_TWO_A 4'h8
`define CODE_MAIN_DELAYED 4'hc
`define CODE_MAIN_LOUDNESS 4'hd
`define CODE_SUBCHANNEL 4'he

// trim register layout
`define TRIM_FIELD_W 6
`define TRIM_MAIN_LSB 8
`define TRIM_HP_LSB 0
`define TRIM_WRITE_MASK 16'h3f3f
`define TRIM_RESET 16'h0e0e
`define TRIM_ZERO_DB 6'h0e
`define TRIM_CODE_MAX 6'h1c
`define GAIN_DB_MAX 6'h0e
`define GAIN_DB_MIN 6'h32

`endif

// [audio_route_pkg.sv]
// types shared by the routing and trim register bank
`include "audio_route_consts.svh"

package audio_route_pkg;

   // one audio sample word
   typedef logic [`SAMPLE_W_DEF-1:0] sample_t;

   // every internal source that an output can pick
   typedef struct packed {
      sample_t conv_in_one;
      sample_t ser_in_zero;
      sample_t ser_in_one;
      sample_t ser_in_two;
      sample_t ser_in_three;
      sample_t rate_conv_one;
      sample_t rate_conv_two_a;
      sample_t main_delayed;
      sample_t main_loudness;
      sample_t subchannel;
   } src_bus_s;

   // whole state of the register bank
   typedef struct packed {
      logic [`REG_DATA_W-1:0] sel;
      logic [`REG_DATA_W-1:0] trim;
      sample_t [2:0] out;
      logic [`REG_DATA_W-1:0] rdata;
      logic rvalid;
      logic [`TRIM_FIELD_W-1:0] main_gain;
      logic [`TRIM_FIELD_W-1:0] hp_gain;
      logic sel_written;
      logic trim_written;
   } bank_state_s;

endpackage

// [source_pick.sv]
// one output's source multiplexer, silent on reserved codes
`timescale 1ns/1ps
`default_nettype none
`include "audio_route_consts.svh"

module source_pick
   import audio_route_pkg::*;
(
   input wire logic [`SRC_FIELD_W-1:0] code_i,
   input wire src_bus_s src_i,
   output sample_t sample_o
);

   // decode the 4-bit source code
   always_comb begin
      case (code_i)
         `CODE_CONV_IN_ONE: sample_o = src_i.conv_in_one;
         `CODE_SER_IN_ZERO: sample_o = src_i.ser_in_zero;
         `CODE_SER_IN_ONE: sample_o = src_i.ser_in_one;
         `CODE_SER_IN_TWO: sample_o = src_i.ser_in_two;
         `CODE_SER_IN_THREE: sample_o = src_i.ser_in_three;
         `CODE_RATE_CONV_ONE: sample_o = src_i.rate_conv_one;
         `CODE_RATE_CONV_TWO_A: sample_o = src_i.rate_conv_two_a;
         `CODE_MAIN_DELAYED: sample_o = src_i.main_delayed;
         `CODE_MAIN_LOUDNESS: sample_o = src_i.main_loudness;
         `CODE_SUBCHANNEL: sample_o = src_i.subchannel;
         default: sample_o = '0;
      endcase
   end

endmodule

`default_nettype wire

// [audio_route_and_trim_regs.sv]
// routing select and input trim registers with their registered source muxes
// Function
// - bits 15:12 pick serial_out_zero source
// - bits 11:8 pick spdif output source
// - bits 7:4 pick aux_output_one source
// - codes 5,6 pick serial two/three
// - codes 7,8 pick rate converters
// - codes c,d pick delayed, loudness main
// - select register resets to zero
// - trim 13:8 sets main gain dB
// - trim 5:0 sets headphone gain dB
// - trim register resets to 0x0e0e
`timescale 1ns/1ps
`default_nettype none
// codes and offsets must be visible even when this file is its own compilation unit
`include "audio_route_consts.svh"

module audio_route_and_trim_regs
   import audio_route_pkg::*;
#(
   parameter int SAMPLE_W = `SAMPLE_W_DEF
)
(
   input wire logic CORE_CLK_I,
   input wire logic ARST_N_I,
   input wire logic CE_I,
   // control port
   input wire logic [`REG_ADDR_W-1:0] REG_ADDR_I,
   input wire logic [`REG_DATA_W-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [`REG_DATA_W-1:0] REG_RDATA_O,
   output logic REG_RVALID_O,
   // audio sources and routed outputs
   input wire src_bus_s SOURCES_I,
   output logic [SAMPLE_W-1:0] SERIAL_OUT_ZERO_O,
   output logic [SAMPLE_W-1:0] SPDIF_OUT_O,
   output logic [SAMPLE_W-1:0] AUX_OUTPUT_ONE_O,
   // signed gain in dB for the two trimmed paths
   output logic [`TRIM_FIELD_W-1:0] MAIN_GAIN_DB_O,
   output logic [`TRIM_FIELD_W-1:0] HP_GAIN_DB_O
);

   // the sample struct is fixed in width, so the port width must match it
   if (SAMPLE_W != $bits(sample_t)) begin : g_bad_width
      $error("SAMPLE_W must equal the package sample width");
   end

   // field lsb of each routed output, index 0 = serial out zero
   localparam int FIELD_LSB [3] = '{`SEL_SERIAL_OUT_ZERO_LSB, `SEL_SPDIF_OUT_LSB,
                                    `SEL_AUX_OUT_ONE_LSB};

   bank_state_s st; // registered state
   bank_state_s next_st; // next state
   sample_t picked [3]; // mux result per output

   // map a trim code to signed dB; codes past the range clamp to the floor
   function automatic logic [`TRIM_FIELD_W-1:0] trim_to_db(
      input logic [`TRIM_FIELD_W-1:0] code
   );
      logic [`TRIM_FIELD_W-1:0] lim;
      lim = (code > `TRIM_CODE_MAX) ? `TRIM_CODE_MAX : code;
      return `TRIM_FIELD_W'(`TRIM_ZERO_DB - lim);
   endfunction

   // one source mux per routed output
   for (genvar g = 0; g < 3; g++) begin : g_pick
      source_pick u_source_pick (
         .code_i(st.sel[FIELD_LSB[g] +: `SRC_FIELD_W]),
         .src_i(SOURCES_I),
         .sample_o(picked[g])
      );
   end

   // register writes, read-back and output staging
   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      if (REG_WR_I) begin
         // only documented offsets take writes, others are dropped
         if (REG_ADDR_I == `OFS_SOURCE_SELECT_TWO) begin
            next_st.sel = REG_WDATA_I & `SEL_WRITE_MASK;
            next_st.sel_written = 1'b1;
         end else if (REG_ADDR_I == `OFS_INPUT_GAIN) begin
            next_st.trim = REG_WDATA_I & `TRIM_WRITE_MASK;
            next_st.trim_written = 1'b1;
         end
      end
      if (REG_RD_I) begin
         // read returns the value held before any write in the same cycle
         next_st.rvalid = 1'b1;
         if (REG_ADDR_I == `OFS_SOURCE_SELECT_TWO) begin
            next_st.rdata = st.sel;
         end else if (REG_ADDR_I == `OFS_INPUT_GAIN) begin
            next_st.rdata = st.trim;
         end else begin
            // unmapped offsets read as zero
            next_st.rdata = '0;
         end
      end
      for (int i = 0; i < 3; i++) begin
         next_st.out[i] = picked[i];
      end
      // gains track the trim value being stored, so both update together
      // main and headphone gain decode
      next_st.main_gain = trim_to_db(next_st.trim[`TRIM_MAIN_LSB +: `TRIM_FIELD_W]);
      next_st.hp_gain = trim_to_db(next_st.trim[`TRIM_HP_LSB +: `TRIM_FIELD_W]);
   end

   // state register; clock enable low freezes everything
   always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         st.sel <= `SEL_RESET;
         st.trim <= `TRIM_RESET;
         st.out <= '0;
         st.rdata <= '0;
         st.rvalid <= 1'b0;
         st.main_gain <= `GAIN_DB_MAX - `TRIM_ZERO_DB;
         st.hp_gain <= `GAIN_DB_MAX - `TRIM_ZERO_DB;
         st.sel_written <= 1'b0;
         st.trim_written <= 1'b0;
      end else if (CE_I) begin
         st <= next_st;
      end
   end

   // ports come straight from the state flip-flops
   assign REG_RDATA_O = st.rdata;
   assign REG_RVALID_O = st.rvalid;
   assign SERIAL_OUT_ZERO_O = st.out[0];
   assign SPDIF_OUT_O = st.out[1];
   assign AUX_OUTPUT_ONE_O = st.out[2];
   assign MAIN_GAIN_DB_O = st.main_gain;
   assign HP_GAIN_DB_O = st.hp_gain;

   // serial out zero follows the converter input one cycle later
   AST_SOUT0_CONV: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      CE_I && st.sel[15:12] == `CODE_CONV_IN_ONE && $stable(st.sel)
      |=> SERIAL_OUT_ZERO_O == $past(SOURCES_I.conv_in_one))
      else $error("serial out zero not fed by converter input");

   // spdif output follows serial input two
   AST_SPDIF_SER2: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      CE_I && st.sel[11:8] == `CODE_SER_IN_TWO
      |=> SPDIF_OUT_O == $past(SOURCES_I.ser_in_two))
      else $error("spdif output not fed by serial input two");

   // aux output one follows rate converter one
   AST_AUX1_RATE1: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      CE_I && st.sel[7:4] == `CODE_RATE_CONV_ONE
      |=> AUX_OUTPUT_ONE_O == $past(SOURCES_I.rate_conv_one))
      else $error("aux output one not fed by rate converter one");

   // serial out zero carries the delayed main tap
   AST_SOUT0_DELAY: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      CE_I && st.sel[15:12] == `CODE_MAIN_DELAYED
      |=> SERIAL_OUT_ZERO_O == $past(SOURCES_I.main_delayed))
      else $error("serial out zero not fed by delayed main");

   // aux output one carries the subchannel
   AST_AUX1_SUB: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      CE_I && st.sel[7:4] == `CODE_SUBCHANNEL
      |=> AUX_OUTPUT_ONE_O == $past(SOURCES_I.subchannel))
      else $error("aux output one not fed by subchannel");

   // reserved code on spdif gives silence
   AST_SPDIF_SILENT: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      CE_I && (st.sel[11:8] == 4'h0 || st.sel[11:8] == 4'h9)
      |=> SPDIF_OUT_O == '0)
      else $error("reserved spdif code did not give silence");

   // select holds zero until software writes it
   AST_SEL_RESET: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      !st.sel_written |-> st.sel == `SEL_RESET && SPDIF_OUT_O == '0)
      else $error("select register left its reset value unwritten");

   // trim holds its reset until written, both paths at 0 dB
   AST_TRIM_RESET: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      !st.trim_written |-> st.trim == `TRIM_RESET && MAIN_GAIN_DB_O == '0
      && HP_GAIN_DB_O == '0)
      else $error("trim register left its reset value unwritten");

   // main trim code ends map to +14 and -14 dB
   AST_MAIN_GAIN: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      (st.trim[13:8] == 6'h00 |-> MAIN_GAIN_DB_O == `GAIN_DB_MAX)
      and (st.trim[13:8] == `TRIM_CODE_MAX |-> MAIN_GAIN_DB_O == `GAIN_DB_MIN))
      else $error("main gain does not match its trim code");

   // headphone trim written to code zero gives +14 dB next cycle
   AST_HP_GAIN: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      CE_I && REG_WR_I && REG_ADDR_I == `OFS_INPUT_GAIN && REG_WDATA_I[5:0] == 6'h00
      |=> HP_GAIN_DB_O == `GAIN_DB_MAX && st.trim[5:0] == 6'h00)
      else $error("headphone gain did not follow a trim write");

   // select read-back answers one cycle later with the stored value
   AST_SEL_READ: assert property (
      @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      CE_I && REG_RD_I && REG_ADDR_I == `OFS_SOURCE_SELECT_TWO
      |=> REG_RVALID_O && REG_RDATA_O == $past(st.sel))
      else $error("select read-back wrong");

endmodule

`default_nettype wire

// [route_host.sv]
// host model that programs the routing and trim registers over the strobe port
`timescale 1ns/1ps
`default_nettype none
`include "audio_route_consts.svh"

module route_host
   import audio_route_pkg::*;
(
   input wire logic clk_i,
   input wire logic [`REG_DATA_W-1:0] rdata_i,
   input wire logic rvalid_i,
   output logic [`REG_ADDR_W-1:0] addr_o,
   output logic [`REG_DATA_W-1:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   // idle port: strobes low, address parked away from both registers
   initial begin
      addr_o = 16'hffff;
      wdata_o = 16'h0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // one write cycle; lax lets a scenario break the reserved-bit habit on purpose
   task automatic write(input logic [15:0] a, input logic [15:0] d, input bit lax);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= (!lax && a == `OFS_INPUT_GAIN) ? (d & `TRIM_WRITE_MASK) : d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= 16'hffff;
      // released data must not look like a held value
      wdata_o <= ~d;
   endtask

   // one read cycle; data and valid are taken just after the answering edge
   task automatic read(input logic [15:0] a, output logic [15:0] d, output logic ok);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= 16'hffff;
      #1;
      d = rdata_i;
      ok = rvalid_i;
   endtask
endmodule
`default_nettype wire

// [audio_route_and_trim_regs_test.sv]
// self-checking bench for the routing and trim register bank
`timescale 1ns/1ps
`default_nettype none
`include "audio_route_consts.svh"

module audio_route_and_trim_regs_test
   import audio_route_pkg::*;
;
   logic clk;
   logic arst_n;
   logic ce;
   logic [`REG_ADDR_W-1:0] addr;
   logic [`REG_DATA_W-1:0] wdata, rdata;
   logic wr, rd, rvalid;
   src_bus_s sources;
   sample_t ser0, spdif, aux1;
   logic [5:0] main_db, hp_db;
   int mismatches;
   int cmp_count;
   // source codes in the order of the source bus fields
   logic [3:0] codes [10] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc, 4'hd, 4'he};
   // reserved codes, only sent by the silence scenario
   logic [3:0] resv [5] = '{4'h0, 4'h2, 4'h9, 4'ha, 4'hb};

   audio_route_and_trim_regs u_audio_route_and_trim_regs (.CORE_CLK_I(clk), .ARST_N_I(arst_n),
      .CE_I(ce), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .SOURCES_I(sources),
      .SERIAL_OUT_ZERO_O(ser0), .SPDIF_OUT_O(spdif), .AUX_OUTPUT_ONE_O(aux1),
      .MAIN_GAIN_DB_O(main_db), .HP_GAIN_DB_O(hp_db));

   route_host u_route_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

   // distinct sample per source so a wrong pick is always visible
   function automatic sample_t val(input int i);
      return sample_t'(24'ha00000 + 24'h010203 * i);
   endfunction

   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // read a register and judge valid and data together
   task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      u_route_host.read(a, d, ok);
      chk("read valid", 24'h1, {23'h0, ok});
      chk("read data", {8'h0, exp}, {8'h0, d});
   endtask

   task automatic t_reset;
      chk("out after reset", 24'h0, ser0 | spdif | aux1);
      chk("gains after reset", 24'h0, {12'h0, main_db, hp_db});
      rdchk(`OFS_SOURCE_SELECT_TWO, 16'h0000);
      rdchk(`OFS_INPUT_GAIN, 16'h0e0e);
   endtask

   // unimplemented bits, unmapped writes and reads
   task automatic t_readback;
      u_route_host.write(`OFS_SOURCE_SELECT_TWO, 16'h5c8f, 1'b0);
      rdchk(`OFS_SOURCE_SELECT_TWO, 16'h5c80);
      // an unmapped write must leave the select register alone
      u_route_host.write(16'h0100, 16'h1111, 1'b0);
      rdchk(`OFS_SOURCE_SELECT_TWO, 16'h5c80);
      rdchk(16'h0103, 16'h0000);
   endtask

   // every valid code on every output, each output a different one
   task automatic t_routes;
      for (int i = 0; i < 10; i++) begin
         u_route_host.write(`OFS_SOURCE_SELECT_TWO,
            {codes[i], codes[(i+3)%10], codes[(i+7)%10], 4'h0}, 1'b0);
         @(posedge clk);
         #1;
         chk("serial out zero", val(i), ser0);
         chk("spdif out", val((i+3)%10), spdif);
         chk("aux out one", val((i+7)%10), aux1);
      end
   endtask

   // reserved codes silence a live output
   task automatic t_reserved;
      for (int r = 0; r < 6; r++) begin
         u_route_host.write(`OFS_SOURCE_SELECT_TWO, 16'h1340, 1'b0);
         // reserved codes are sent here on purpose, to see the outputs go quiet
         u_route_host.write(`OFS_SOURCE_SELECT_TWO,
            (r < 5) ? {resv[r], resv[r], resv[r], 4'h0} : 16'hfff0, 1'b0);
         @(posedge clk);
         #1;
         chk("silent outputs", 24'h0, ser0 | spdif | aux1);
      end
   endtask

   // whole trim code range on both fields, then out-of-range codes
   task automatic t_gain;
      for (int c = 0; c <= 28; c++) begin
         u_route_host.write(`OFS_INPUT_GAIN, {2'b00, 6'(c), 2'b00, 6'(28 - c)}, 1'b0);
         #1;
         chk("main gain", {18'h0, 6'(14 - c)}, {18'h0, main_db});
         chk("hp gain", {18'h0, 6'(c - 14)}, {18'h0, hp_db});
      end
      // lax write puts ones into the reserved bits to see them dropped
      u_route_host.write(`OFS_INPUT_GAIN, 16'hffff, 1'b1);
      #1;
      chk("clamped gains", 24'h000cb2, {12'h0, main_db, hp_db});
      rdchk(`OFS_INPUT_GAIN, 16'h3f3f);
   endtask

   // clock enable low freezes the audio path and refuses register writes
   task automatic t_enable;
      u_route_host.write(`OFS_SOURCE_SELECT_TWO, 16'h1340, 1'b0);
      @(posedge clk);
      ce <= 1'b0;
      sources[239:216] <= ~val(0);
      // this write meets a low enable and must be dropped, else the output goes silent
      u_route_host.write(`OFS_SOURCE_SELECT_TWO, 16'h0000, 1'b0);
      ce <= 1'b1;
      #1;
      chk("frozen output", val(0), ser0);
      repeat (2) @(posedge clk);
      #1;
      chk("resumed output", ~val(0), ser0);
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
   end

   // 20 MHz core clock
   always #25 clk = ~clk;

   initial begin
      mismatches = 0;
      cmp_count = 0;
      ce = 1'b1;
      arst_n = 1'b0;
      for (int i = 0; i < 10; i++) begin
         sources[24*(9-i) +: 24] = val(i);
      end
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      t_readback();
      t_routes();
      t_reserved();
      t_gain();
      t_enable();
      // second reset in mid-run must bring back both reset values
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      close_out();
   end

   // whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      close_out();
   end
endmodule
`default_nettype wire
